// File: thcal_ctrl.v
// Purpose: calibration sequencer and track/hold control with AXI4-Lite
// Assumes: pins select_n, trim_req, reset_req, freeze_n asynchronous
// Notes:   register bits OR with pins except freeze, which ANDs; busy while state_r is not idle
`timescale 1ns/1ps
`include "thcal_regs.vh"

// How it works
// - trim request with select low starts calibration
// - trim done low through 4 ms calibration
// - latch must go low then high again
// - request during calibration runs after current
// - reset with select strobe clears latch
// - done drops on reset or calibration start
// - freeze falling edge enters hold mode
// - freeze high enters track, acquire then follow
// - reset and trim only act under select
// - calibration grounds input, captures, nulls DAC
// - calibration may be requested any time
// - done rises within 10 ms of request
module thcal_ctrl #(
   parameter CAL_CYCLES = `THCAL_CAL_CYCLES,
   parameter DAC_W      = `THCAL_DAC_W
) (
   ref_clk,
   resetn,
   select_n,
   trim_req,
   reset_req,
   freeze_n,
   cmp_high,
   trim_done,
   hold_mode,
   acquiring,
   input_disconnect,
   ground_connect,
   sample_capture,
   dac_code,
   irq,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input  wire             ref_clk;
   input  wire             resetn;
   input  wire             select_n;
   input  wire             trim_req;
   input  wire             reset_req;
   input  wire             freeze_n;
   input  wire             cmp_high;
   output reg              trim_done;
   output reg              hold_mode;
   output reg              acquiring;
   output reg              input_disconnect;
   output reg              ground_connect;
   output reg              sample_capture;
   output wire [DAC_W-1:0] dac_code;
   output wire             irq;
   input  wire [7:0]       s_axi_awaddr;
   input  wire             s_axi_awvalid;
   output wire             s_axi_awready;
   input  wire [31:0]      s_axi_wdata;
   input  wire [3:0]       s_axi_wstrb;
   input  wire             s_axi_wvalid;
   output wire             s_axi_wready;
   output reg  [1:0]       s_axi_bresp;
   output reg              s_axi_bvalid;
   input  wire             s_axi_bready;
   input  wire [7:0]       s_axi_araddr;
   input  wire             s_axi_arvalid;
   output wire             s_axi_arready;
   output reg  [31:0]      s_axi_rdata;
   output reg  [1:0]       s_axi_rresp;
   output reg              s_axi_rvalid;
   input  wire             s_axi_rready;

   localparam [2:0] ST_IDLE    = 3'd0;
   localparam [2:0] ST_GROUND  = 3'd1;
   localparam [2:0] ST_CAPTURE = 3'd2;
   localparam [2:0] ST_NULL    = 3'd3;
   localparam [2:0] ST_SETTLE  = 3'd4;
   localparam [31:0] ACQ_CYCLES  = 32'd40;   // acquire window, 1 us
   localparam [31:0] PHASE_CYCLES = 32'd64;  // ground and capture phases
   localparam [31:0] STEP_CYCLES = 32'd256;  // per DAC search step

   // synchronised pins
   wire sel_n_s;
   wire trim_s;
   wire rst_s;
   wire frz_s;
   thcal_sync2 u_sync_sel (.ref_clk(ref_clk), .resetn(resetn), .d_in(select_n), .q_out(sel_n_s));
   thcal_sync2 u_sync_trm (.ref_clk(ref_clk), .resetn(resetn), .d_in(trim_req), .q_out(trim_s));
   thcal_sync2 u_sync_rst (.ref_clk(ref_clk), .resetn(resetn), .d_in(reset_req), .q_out(rst_s));
   thcal_sync2 u_sync_frz (.ref_clk(ref_clk), .resetn(resetn), .d_in(freeze_n), .q_out(frz_s));
   wire cmp_s;
   thcal_sync2 u_sync_cmp (.ref_clk(ref_clk), .resetn(resetn), .d_in(cmp_high), .q_out(cmp_s));

   // registers
   reg [3:0]  ctrl_r;
   reg [2:0]  irq_stat_r;
   reg [2:0]  irq_mask_r;
   reg        aw_got_r;
   reg        w_got_r;
   reg [7:0]  aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0]  w_strb_r;

   // merged pin and register controls, active high except frz_in, which is high for track
   wire sel_act = ~sel_n_s | ctrl_r[`THCAL_CTRL_SELECT];
   wire trim_in = trim_s | ctrl_r[`THCAL_CTRL_TRIM];
   wire rst_in  = rst_s | ctrl_r[`THCAL_CTRL_RESET];
   wire frz_in  = frz_s & ctrl_r[`THCAL_CTRL_FREEZE];

   // request latch, loaded only while selected
   reg latch_r;
   reg latch_prev_r;
   reg pend_r;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         latch_r      <= 1'b0;
         latch_prev_r <= 1'b0;
      end else begin
         latch_prev_r <= latch_r;
         if (sel_act) begin
            if (rst_in)
               latch_r <= 1'b0;
            else
               latch_r <= trim_in;
         end
      end
   end
   // only a fresh low-to-high load counts as a request
   wire new_req = latch_r & ~latch_prev_r;
   wire sel_rst = sel_act & rst_in;

   // sequencer
   reg [2:0]  state_r;
   reg [31:0] cnt_r;
   reg        null_start_r;
   wire       null_step = (state_r == ST_NULL) && (cnt_r == STEP_CYCLES - 32'd1);
   wire       null_fin;
   wire       cal_busy = (state_r != ST_IDLE);
   wire       go = (state_r == ST_IDLE) && (new_req || pend_r);

   thcal_nuller #(.DAC_W(DAC_W)) u_null (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .start    (null_start_r),
      .step     (null_step),
      .cmp_high (cmp_s),
      .dac_code (dac_code),
      .finished (null_fin)
   );

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r      <= ST_IDLE;
         cnt_r        <= 32'd0;
         pend_r       <= 1'b0;
         trim_done    <= 1'b0;
         null_start_r <= 1'b0;
      end else begin
         null_start_r <= 1'b0;
         cnt_r        <= cnt_r + 32'd1;
         // request during a run is queued
         if (new_req && cal_busy)
            pend_r <= 1'b1;
         else if (go)
            pend_r <= 1'b0;
         if (sel_rst && !cal_busy)
            trim_done <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               cnt_r <= 32'd0;
               if (go) begin
                  trim_done <= 1'b0;
                  state_r   <= ST_GROUND;
               end
            end
            ST_GROUND: if (cnt_r == PHASE_CYCLES - 32'd1) begin
               state_r <= ST_CAPTURE;
               cnt_r   <= 32'd0;
            end
            ST_CAPTURE: if (cnt_r == PHASE_CYCLES - 32'd1) begin
               state_r      <= ST_NULL;
               cnt_r        <= 32'd0;
               null_start_r <= 1'b1;
            end
            ST_NULL: begin
               if (null_step)
                  cnt_r <= 32'd0;
               if (null_fin && !null_start_r)
                  state_r <= ST_SETTLE;
            end
            ST_SETTLE: if (cnt_r >= CAL_CYCLES - 32'd1) begin
               state_r   <= ST_IDLE;
               cnt_r     <= 32'd0;
               trim_done <= 1'b1;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // analog switch controls during calibration
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         input_disconnect <= 1'b0;
         ground_connect   <= 1'b0;
         sample_capture   <= 1'b0;
      end else begin
         input_disconnect <= (go || cal_busy) && !(state_r == ST_SETTLE);
         ground_connect   <= (go || cal_busy) && !(state_r == ST_SETTLE);
         sample_capture   <= (state_r == ST_CAPTURE) || (state_r == ST_NULL);
      end
   end

   // track/hold: hold on freeze falling edge, track on freeze high level
   reg        frz_prev_r;
   reg [31:0] acq_cnt_r;
   wire       frz_fall = frz_prev_r & ~frz_in;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         frz_prev_r <= 1'b0;                     // synced pin reads low in reset
         hold_mode  <= 1'b0;
         acquiring  <= 1'b0;
         acq_cnt_r  <= 32'd0;
      end else begin
         frz_prev_r <= frz_in;
         if (frz_fall) begin
            hold_mode <= 1'b1;
            acquiring <= 1'b0;
         end else if (frz_in && hold_mode) begin
            hold_mode <= 1'b0;
            acquiring <= 1'b1;
            acq_cnt_r <= 32'd0;
         end else if (acquiring) begin
            acq_cnt_r <= acq_cnt_r + 32'd1;
            if (acq_cnt_r == ACQ_CYCLES - 32'd1)
               acquiring <= 1'b0;
         end
      end
   end

   // interrupt events; set wins over clear
   wire [2:0] irq_evt = {frz_fall, go, (state_r == ST_SETTLE) && (cnt_r >= CAL_CYCLES - 32'd1)};
   wire       wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
   wire [2:0] irq_clr = (wr_fire && aw_addr_r == `THCAL_IRQ_STAT_OFF && w_strb_r[0]) ?
                        w_data_r[2:0] : 3'b000;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         irq_stat_r <= 3'b000;
      else
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   // axi write channel capture
   assign s_axi_awready = !aw_got_r;
   assign s_axi_wready  = !w_got_r;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         aw_got_r     <= 1'b0;
         w_got_r      <= 1'b0;
         aw_addr_r    <= 8'h00;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         ctrl_r       <= `THCAL_CTRL_RST_VAL;
         irq_mask_r   <= 3'b000;
      end else begin
         if (s_axi_awvalid && !aw_got_r) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_got_r) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            if (aw_addr_r == `THCAL_CTRL_OFF && w_strb_r[0])
               ctrl_r <= w_data_r[3:0];
            else if (aw_addr_r == `THCAL_IRQ_MASK_OFF && w_strb_r[0])
               irq_mask_r <= w_data_r[2:0];
            else if (aw_addr_r != `THCAL_IRQ_STAT_OFF && aw_addr_r != `THCAL_STAT_OFF &&
                     aw_addr_r != `THCAL_DAC_OFF && aw_addr_r != `THCAL_CTRL_OFF &&
                     aw_addr_r != `THCAL_IRQ_MASK_OFF)
               s_axi_bresp <= 2'b10;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
         end
      end
   end

   // axi read channel
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr)
            `THCAL_CTRL_OFF:     s_axi_rdata <= {28'h000_0000, ctrl_r};
            `THCAL_STAT_OFF:     s_axi_rdata <= {27'h000_0000, latch_r, hold_mode,
                                                 pend_r, cal_busy, trim_done};
            `THCAL_IRQ_STAT_OFF: s_axi_rdata <= {29'h0000_0000, irq_stat_r};
            `THCAL_IRQ_MASK_OFF: s_axi_rdata <= {29'h0000_0000, irq_mask_r};
            `THCAL_DAC_OFF:      s_axi_rdata <= {{(32-DAC_W){1'b0}}, dac_code};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // thcal_ctrl

// File: thcal_regs.vh
// Purpose: constants for the track/hold calibration controller
// Assumes: 40 MHz ref_clk, AXI4-Lite register access
// Notes:   byte offsets, field positions, reset values and timing counts
`ifndef THCAL_REGS_VH
`define THCAL_REGS_VH

// register byte offsets
`define THCAL_CTRL_OFF      8'h00
`define THCAL_STAT_OFF      8'h04
`define THCAL_IRQ_STAT_OFF  8'h08
`define THCAL_IRQ_MASK_OFF  8'h0C
`define THCAL_DAC_OFF       8'h10

// control register fields
`define THCAL_CTRL_TRIM     0
`define THCAL_CTRL_RESET    1
`define THCAL_CTRL_SELECT   2
`define THCAL_CTRL_FREEZE   3
`define THCAL_CTRL_RST_VAL  4'h8

// status register fields
`define THCAL_STAT_DONE     0
`define THCAL_STAT_BUSY     1
`define THCAL_STAT_PEND     2
`define THCAL_STAT_HOLD     3
`define THCAL_STAT_LATCH    4

// interrupt bits
`define THCAL_IRQ_DONE      0
`define THCAL_IRQ_START     1
`define THCAL_IRQ_HOLD      2

// timing
`define THCAL_CLK_HZ        40000000
`define THCAL_CAL_TIME_US   4000
`define THCAL_CAL_CYCLES    ((`THCAL_CLK_HZ / 1000000) * `THCAL_CAL_TIME_US)
`define THCAL_MAX_TIME_US   10000
`define THCAL_MAX_CYCLES    ((`THCAL_CLK_HZ / 1000000) * `THCAL_MAX_TIME_US)
`define THCAL_DAC_W         8

`endif

// File: thcal_sync2.v
// Purpose: two-flop synchroniser for a pin level
// Assumes: input is asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module thcal_sync2 (
   ref_clk,
   resetn,
   d_in,
   q_out
);
   input  wire ref_clk;
   input  wire resetn;
   input  wire d_in;
   output wire q_out;

   reg meta_r;
   reg sync_r;

   // two flops in series
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= d_in;
         sync_r <= meta_r;
      end
   end

   assign q_out = sync_r;
endmodule // thcal_sync2

// File: thcal_nuller.v
// Purpose: correction DAC search during calibration
// Assumes: comparator result from held ground sample, synchronised
// Notes:   successive approximation, one bit per step
`timescale 1ns/1ps
module thcal_nuller #(
   parameter DAC_W = 8
) (
   ref_clk,
   resetn,
   start,
   step,
   cmp_high,
   dac_code,
   finished
);
   input  wire             ref_clk;
   input  wire             resetn;
   input  wire             start;
   input  wire             step;
   input  wire             cmp_high;
   output reg  [DAC_W-1:0] dac_code;
   output reg              finished;

   reg [DAC_W-1:0] trial_r;

   // binary search: keep bit unless the held error says too high
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dac_code <= {DAC_W{1'b0}};
         trial_r  <= {DAC_W{1'b0}};
         finished <= 1'b0;
      end else if (start) begin
         dac_code <= {1'b1, {(DAC_W-1){1'b0}}};
         trial_r  <= {1'b1, {(DAC_W-1){1'b0}}};
         finished <= 1'b0;
      end else if (step && !finished) begin
         if (trial_r[0]) begin
            finished <= 1'b1;
            if (cmp_high)
               dac_code <= dac_code & ~trial_r;
         end else begin
            dac_code <= (cmp_high ? (dac_code & ~trial_r) : dac_code) | (trial_r >> 1);
            trial_r  <= trial_r >> 1;
         end
      end
   end
endmodule // thcal_nuller

// File: thcal_host_model.sv
// Purpose: far-side control latches driving the select strobe and data lines
// Assumes: lines change just after a rising edge, strobe spans several cycles
// Notes:   data lines stay latched between strobes, as external latches do
`timescale 1ns/1ps
module thcal_host_model (
   input  wire logic ref_clk,
   output logic      select_n,
   output logic      trim_req,
   output logic      reset_req
);
   // idle: not selected, latches low
   initial begin
      select_n  = 1'b1;
      trim_req  = 1'b0;
      reset_req = 1'b0;
   end

   // load lines, then strobe select low when s is set
   task automatic drive(input logic t, input logic r, input logic s);
      @(posedge ref_clk);
      trim_req  <= t;
      reset_req <= r;
      repeat (2) @(posedge ref_clk);
      select_n  <= ~s;
      repeat (4) @(posedge ref_clk);
      select_n  <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule // thcal_host_model

// File: thcal_ctrl_asserts.sv
// Purpose: port-level checks of calibration, freeze and response timing
// Assumes: single ref_clk domain, resetn async active low
// Notes:   calibration length bounded through a helper counter
`timescale 1ns/1ps
module thcal_ctrl_asserts #(
   parameter CAL_CYCLES = 160000
) (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       freeze_n,
   input wire logic       trim_done,
   input wire logic       hold_mode,
   input wire logic       acquiring,
   input wire logic       input_disconnect,
   input wire logic       ground_connect,
   input wire logic       sample_capture,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic [1:0] s_axi_bresp
);
   logic [31:0] busy_cnt_r;
   logic [31:0] busy_cnt_nxt;

   // cycles from calibration start until done rises, settle phase included
   assign busy_cnt_nxt = trim_done ? '0 :
                         (input_disconnect || sample_capture || busy_cnt_r != '0) ?
                         busy_cnt_r + 32'h0000_0001 : '0;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_cnt_r <= '0;
      end else begin
         busy_cnt_r <= busy_cnt_nxt;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_done_low;
      (input_disconnect || sample_capture) |-> !trim_done;
   endproperty
   a_done_low: assert property (p_done_low) else $error("done high while calibrating");
   property p_ground;
      input_disconnect == ground_connect;
   endproperty
   a_ground: assert property (p_ground) else $error("ground not switched with input");
   property p_capture;
      sample_capture |-> ground_connect;
   endproperty
   a_capture: assert property (p_capture) else $error("capture without ground");
   property p_hold;
      $fell(freeze_n) |-> ##[1:5] hold_mode;
   endproperty
   a_hold: assert property (p_hold) else $error("hold not entered");
   property p_track;
      $rose(freeze_n) |-> ##[1:5] !hold_mode;
   endproperty
   a_track: assert property (p_track) else $error("track not entered");
   property p_acquire;
      $fell(hold_mode) |-> ##[0:1] acquiring [*8];
   endproperty
   a_acquire: assert property (p_acquire) else $error("no acquire after hold");
   property p_acq_excl;
      acquiring |-> !hold_mode;
   endproperty
   a_acq_excl: assert property (p_acq_excl) else $error("acquiring while held");
   property p_bound;
      busy_cnt_r <= CAL_CYCLES + 4000;
   endproperty
   a_bound: assert property (p_bound) else $error("calibration too long");
   property p_bstand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bstand: assert property (p_bstand) else $error("write response dropped");

   c_done: cover property ($rose(trim_done));
   c_hold: cover property ($rose(hold_mode));
   c_cal: cover property ($rose(ground_connect));
endmodule // thcal_ctrl_asserts

bind thcal_ctrl thcal_ctrl_asserts #(.CAL_CYCLES(CAL_CYCLES)) i_thcal_ctrl_asserts (
   .ref_clk, .resetn, .freeze_n, .trim_done, .hold_mode, .acquiring, .input_disconnect,
   .ground_connect, .sample_capture, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp
);

// File: thcal_ctrl_test.sv
// Purpose: self-checking bench for the calibration controller
// Assumes: shortened settle count, 40 MHz ref_clk
// Notes:   select, trim and reset pins come from the latch model, registers over AXI4-Lite
`timescale 1ns/1ps
module thcal_ctrl_test;
   logic ref_clk, resetn, freeze_n, cmp_high, select_n, trim_req, reset_req;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, d;
   logic [1:0] r;
   wire trim_done, hold_mode, acquiring, input_disconnect, ground_connect, sample_capture, irq;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] dac_code;
   int miscompares, num_checks, ncal;
   // address, response, data after reset
   logic [41:0] rows [6] = '{{8'h00, 2'h0, 32'h0000_0008}, {8'h04, 2'h0, 32'h0000_0000},
      {8'h08, 2'h0, 32'h0000_0000}, {8'h0C, 2'h0, 32'h0000_0000},
      {8'h10, 2'h0, 32'h0000_0000}, {8'h14, 2'h2, 32'h0000_0000}};

   thcal_host_model i_thcal_host_model (.ref_clk(ref_clk), .select_n(select_n),
      .trim_req(trim_req), .reset_req(reset_req));
   thcal_ctrl #(.CAL_CYCLES(200)) i_thcal_ctrl (.ref_clk(ref_clk), .resetn(resetn),
      .select_n(select_n), .trim_req(trim_req), .reset_req(reset_req), .freeze_n(freeze_n),
      .cmp_high(cmp_high), .trim_done(trim_done), .hold_mode(hold_mode), .acquiring(acquiring),
      .input_disconnect(input_disconnect), .ground_connect(ground_connect),
      .sample_capture(sample_capture), .dac_code(dac_code), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // clock and calibration counter
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ground_connect) ncal++;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // wait until n calibrations were seen and done is high
   task automatic wait_cal(input int n);
      int k;
      for (k = 0; k < 20000 && !(ncal >= n && trim_done === 1'b1); k++) @(posedge ref_clk);
      chk(ncal, n, "calibrations");
   endtask
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog
   initial begin
      #(25 * 60000);
      miscompares++;
      report_and_stop;
   end

   // main sequence
   initial begin
      resetn = 0; freeze_n = 1; cmp_high = 0; awvalid = 0; wvalid = 0; bready = 0;
      arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0; ncal = 0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i][41:34]);
         chk(d, rows[i][31:0], "reset read");
         chk(r, rows[i][33:32], "read resp");
      end
      i_thcal_host_model.drive(0, 1, 1);
      i_thcal_host_model.drive(1, 0, 1);
      wait_cal(1);
      rd(8'h04);
      chk(d, 32'h0000_0011, "status done");
      chk(dac_code, 32'h0000_00FF, "dac search low");
      i_thcal_host_model.drive(1, 0, 1);
      i_thcal_host_model.drive(0, 0, 0);
      i_thcal_host_model.drive(1, 0, 0);
      repeat (100) @(posedge ref_clk);
      chk(ncal, 1, "no restart");
      chk(trim_done, 1, "done stays");
      i_thcal_host_model.drive(0, 0, 1);
      i_thcal_host_model.drive(1, 0, 1);
      chk(trim_done, 0, "done at start");
      i_thcal_host_model.drive(0, 0, 1);
      i_thcal_host_model.drive(1, 0, 1);
      rd(8'h04);
      chk(d[2], 1, "pending");
      wait_cal(3);
      i_thcal_host_model.drive(0, 1, 1);
      rd(8'h04);
      chk(d, 0, "status after reset");
      i_thcal_host_model.drive(0, 0, 1);
      wr(8'h0C, 32'h0000_0001);
      cmp_high <= 1'b1;
      wr(8'h00, 32'h0000_000D);
      wait_cal(4);
      chk(dac_code, 32'h0000_0000, "dac search high");
      chk(irq, 1, "irq done");
      wr(8'h0C, 32'h0000_0000);
      chk(irq, 0, "irq masked");
      wr(8'h0C, 32'h0000_0001);
      wr(8'h08, 32'h0000_0007);
      chk(irq, 0, "irq cleared");
      wr(8'h00, 32'h0000_000C);
      wr(8'h00, 32'h0000_0008);
      rd(8'h04);
      chk(d, 32'h0000_0001, "latch low");
      wr(8'h14, 32'h0000_0001);
      chk(r, 2'h2, "unmapped write");
      @(posedge ref_clk);
      freeze_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk(hold_mode, 1, "hold");
      freeze_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk({hold_mode, acquiring}, 2'b01, "acquire");
      repeat (60) @(posedge ref_clk);
      chk(acquiring, 0, "tracking");
      i_thcal_host_model.drive(1, 0, 1);
      repeat (300) @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (12) @(posedge ref_clk);
      chk(trim_done, 0, "done in reset");
      resetn <= 1'b1;
      rd(8'h00);
      chk(d, 32'h0000_0008, "control after reset");
      rd(8'h08);
      chk(d, 32'h0000_0000, "no event after reset");
      chk(hold_mode, 0, "track after reset");
      report_and_stop;
   end
endmodule // thcal_ctrl_test
